// ==== pgef_core.sv ====
// Pixel grabber, exposure readout and frame period counter of the motion sensor.
// Assumes a serial port decoder on the link clock that issues one register access at a time
// and an imaging array that streams 324 pixels column by column after each frame start.
//
// Functional notes
// - Pixel port bits 5..0 carry the unsigned pixel intensity, 0 black to 63 white.
// - Pixel port bit 7 reads 1 only for pixel number one.
// - Pixel port bit 6 shows that the grabber holds a valid sample.
// - Any write to the pixel port restarts the grabber at pixel one.
// - Each read of the pixel port that finds a held sample steps the pixel index by one.
// - After 324 valid reads the index wraps back to pixel one.
// - Only one pixel is captured per frame.
// - Any pixel port access arms capture from the next frame; sample held until read.
// - Pixels are numbered column by column, 18 by 18, bottom of first column first.
// - Exposure is a 16-bit clock count in two byte registers, default 0x0100.
// - Auto exposure keeps the brightest pixel in the mid fifties.
// - Each exposure change is plus or minus one sixteenth of its value.
// - Exposure is capped at clocks per frame minus 3476, or at 1 in frames of 3476 clocks or fewer.
// - Frame period is a 16-bit up counter reloaded from the interval upper byte.
// - Frame interval register is read/write and resets to 0xc2.
// - Stay awake bit set keeps the sensor awake; clear sleeps after one idle second.
`timescale 1ns/10ps
module pgef_core #(
	parameter int SLEEP_CYCLES = pgef_pkg::SLEEP_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_lnk_clk,
	input  wire logic [6:0]  i_lnk_addr,
	input  wire logic        i_lnk_rd,
	input  wire logic        i_lnk_wr,
	input  wire logic [7:0]  i_lnk_wdata,
	output logic [7:0]       o_lnk_rdata,
	output logic             o_lnk_ack,
	output logic             o_lnk_busy,
	input  wire logic        i_pix_valid,
	input  wire logic [5:0]  i_pix_value,
	input  wire logic        i_stay_awake_bit,
	input  wire logic        i_motion,
	output logic             o_frame_start,
	output logic             o_shutter_open,
	output logic             o_awake,
	output logic [15:0]      o_exposure,
	output logic [7:0]       o_frame_interval
);
	typedef enum logic [1:0] {
		PGEF_IDLE,
		PGEF_ARMED,
		PGEF_CAPTURE,
		PGEF_HELD
	} pgef_grab_e;

	// Link domain: request capture and answer return
	logic       lnk_busy_q;
	logic       lnk_req_tgl_q;
	logic [6:0] lnk_addr_q;
	logic [7:0] lnk_wdata_q;
	logic       lnk_wr_q;
	logic       lnk_ack_seen_q;
	logic       lnk_ack_s;
	logic [7:0] core_rdata_q;
	logic       core_ack_tgl_q;
	logic       lnk_take_w;
	logic       lnk_done_w;

	assign lnk_take_w = (i_lnk_rd | i_lnk_wr) & ~lnk_busy_q;
	assign lnk_done_w = lnk_busy_q & (lnk_ack_s != lnk_ack_seen_q);
	assign o_lnk_busy = lnk_busy_q;

	pgef_sync u_ack_sync (
		.i_clk (i_lnk_clk),
		.i_rst (i_rst),
		.i_d   (core_ack_tgl_q),
		.o_q   (lnk_ack_s)
	);

	always_ff @(posedge i_lnk_clk or posedge i_rst) begin
		if (i_rst) begin
			lnk_busy_q     <= 1'b0;
			lnk_req_tgl_q  <= 1'b0;
			lnk_addr_q     <= 7'h00;
			lnk_wdata_q    <= 8'h00;
			lnk_wr_q       <= 1'b0;
			lnk_ack_seen_q <= 1'b0;
			o_lnk_rdata    <= 8'h00;
			o_lnk_ack      <= 1'b0;
		end else begin
			o_lnk_ack <= lnk_done_w;
			if (lnk_take_w) begin
				lnk_busy_q    <= 1'b1;
				lnk_req_tgl_q <= ~lnk_req_tgl_q;
				lnk_addr_q    <= i_lnk_addr;
				lnk_wdata_q   <= i_lnk_wdata;
				lnk_wr_q      <= i_lnk_wr;
			end else if (lnk_done_w) begin
				lnk_busy_q     <= 1'b0;
				lnk_ack_seen_q <= lnk_ack_s;
				o_lnk_rdata    <= core_rdata_q;
			end
		end
	end

	// Core domain: access detection
	logic req_s;
	logic req_seen_q;
	logic acc_w;
	logic acc_rd_w;
	logic acc_wr_w;
	logic pix_rd_w;
	logic pix_wr_w;
	logic exph_rd_w;
	logic fint_wr_w;

	pgef_sync u_req_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (lnk_req_tgl_q),
		.o_q   (req_s)
	);

	assign acc_w     = req_s != req_seen_q;
	assign acc_rd_w  = acc_w & ~lnk_wr_q;
	assign acc_wr_w  = acc_w & lnk_wr_q;
	assign pix_rd_w  = acc_rd_w & (lnk_addr_q == pgef_pkg::A_PIXEL_PORT);
	assign pix_wr_w  = acc_wr_w & (lnk_addr_q == pgef_pkg::A_PIXEL_PORT);
	assign exph_rd_w = acc_rd_w & (lnk_addr_q == pgef_pkg::A_EXP_HIGH);
	assign fint_wr_w = acc_wr_w & (lnk_addr_q == pgef_pkg::A_FRAME_INT);

	// Frame period counter
	logic [15:0] frame_cnt_q;
	logic        frame_wrap_w;
	logic [16:0] frame_clks_w;
	logic [15:0] exp_limit_w;

	assign frame_wrap_w  = frame_cnt_q == pgef_pkg::FRAME_WRAP;
	assign frame_clks_w  = pgef_pkg::FRAME_SPAN - {1'b0, o_frame_interval, 8'h00};
	assign exp_limit_w   = (frame_clks_w > pgef_pkg::EXP_OVH) ?
		16'(frame_clks_w - pgef_pkg::EXP_OVH) : 16'h0001;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frame_cnt_q      <= {pgef_pkg::FRAME_INT_RST, 8'h00};
			o_frame_interval <= pgef_pkg::FRAME_INT_RST;
			o_frame_start    <= 1'b0;
		end else begin
			o_frame_start <= frame_wrap_w;
			if (fint_wr_w) begin
				o_frame_interval <= lnk_wdata_q;
			end
			if (frame_wrap_w) begin
				frame_cnt_q <= {o_frame_interval, 8'h00};
			end else begin
				frame_cnt_q <= frame_cnt_q + 16'h0001;
			end
		end
	end

	// Shutter window and per-frame pixel stream tracking
	logic [15:0] shut_cnt_q;
	logic [8:0]  stream_idx_q;
	logic [5:0]  frame_max_q;
	logic [5:0]  max_next_w;

	assign max_next_w = (i_pix_valid && i_pix_value > frame_max_q) ? i_pix_value : frame_max_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shut_cnt_q     <= 16'h0000;
			o_shutter_open <= 1'b0;
			stream_idx_q   <= 9'h000;
			frame_max_q    <= 6'h00;
		end else begin
			if (o_frame_start) begin
				shut_cnt_q     <= 16'h0000;
				o_shutter_open <= 1'b1;
				stream_idx_q   <= 9'h000;
				frame_max_q    <= 6'h00;
			end else begin
				if (o_shutter_open) begin
					shut_cnt_q <= shut_cnt_q + 16'h0001;
				end
				if (o_shutter_open && shut_cnt_q + 16'h0001 >= o_exposure) begin
					o_shutter_open <= 1'b0;
				end
				if (i_pix_valid && stream_idx_q != pgef_pkg::PIX_LAST) begin
					stream_idx_q <= stream_idx_q + 9'h001;
				end
				frame_max_q <= max_next_w;
			end
		end
	end

	pgef_auto_exposure u_auto_exposure_loop (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_frame_end (frame_wrap_w),
		.i_max_pix   (max_next_w),
		.i_limit     (exp_limit_w),
		.o_exposure  (o_exposure)
	);

	// Sleep timer
	logic [31:0] idle_cnt_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			idle_cnt_q <= 32'h00000000;
			o_awake    <= 1'b1;
		end else begin
			if (i_stay_awake_bit || i_motion) begin
				idle_cnt_q <= 32'h00000000;
				o_awake    <= 1'b1;
			end else if (idle_cnt_q >= 32'(SLEEP_CYCLES - 1)) begin
				o_awake <= 1'b0;
			end else begin
				idle_cnt_q <= idle_cnt_q + 32'h00000001;
			end
		end
	end

	// Frame grabber
	pgef_grab_e  grab_q;
	pgef_grab_e  grab_d;
	logic [8:0]  pix_idx_q;
	logic [8:0]  pix_idx_d;
	logic [5:0]  sample_q;
	logic        cap_w;
	logic        held_w;
	logic        adv_w;
	logic [7:0]  pix_port_w;
	logic [7:0]  exp_low_q;
	logic [7:0]  rdata_w;

	assign held_w     = grab_q == PGEF_HELD;
	assign cap_w      = (grab_q == PGEF_CAPTURE) && i_pix_valid && o_awake && (stream_idx_q == pix_idx_q) &&
		!pix_rd_w && !pix_wr_w;
	assign adv_w      = pix_rd_w & held_w;
	assign pix_port_w = {pix_idx_q == 9'h000, held_w, sample_q};

	always_comb begin
		grab_d    = grab_q;
		pix_idx_d = pix_idx_q;
		case (grab_q)
			PGEF_IDLE: begin
				if (o_frame_start) begin
					grab_d = PGEF_IDLE;
				end
			end
			PGEF_ARMED: begin
				if (o_frame_start) begin
					grab_d = PGEF_CAPTURE;
				end
			end
			PGEF_CAPTURE: begin
				if (cap_w) begin
					grab_d = PGEF_HELD;
				end else if (o_frame_start) begin
					grab_d = PGEF_CAPTURE;
				end
			end
			PGEF_HELD: begin
				grab_d = PGEF_HELD;
			end
			default: begin
				grab_d = PGEF_IDLE;
			end
		endcase
		if (pix_wr_w) begin
			pix_idx_d = 9'h000;
			grab_d    = PGEF_ARMED;
		end else if (pix_rd_w) begin
			grab_d = PGEF_ARMED;
			if (adv_w) begin
				pix_idx_d = (pix_idx_q == pgef_pkg::PIX_LAST) ? 9'h000 : pix_idx_q + 9'h001;
			end
		end
	end

	always_comb begin
		case (lnk_addr_q)
			pgef_pkg::A_PIXEL_PORT: rdata_w = pix_port_w;
			pgef_pkg::A_EXP_HIGH:   rdata_w = o_exposure[15:8];
			pgef_pkg::A_EXP_LOW:    rdata_w = exp_low_q;
			pgef_pkg::A_FRAME_INT:  rdata_w = o_frame_interval;
			default:                rdata_w = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			grab_q         <= PGEF_IDLE;
			pix_idx_q      <= 9'h000;
			sample_q       <= pgef_pkg::PIXEL_RST[5:0];
			exp_low_q      <= pgef_pkg::EXP_RST[7:0];
			req_seen_q     <= 1'b0;
			core_rdata_q   <= 8'h00;
			core_ack_tgl_q <= 1'b0;
		end else begin
			grab_q    <= grab_d;
			pix_idx_q <= pix_idx_d;
			if (cap_w) begin
				sample_q <= i_pix_value;
			end
			if (exph_rd_w) begin
				exp_low_q <= o_exposure[7:0];
			end
			if (acc_w) begin
				req_seen_q     <= req_s;
				core_rdata_q   <= rdata_w;
				core_ack_tgl_q <= ~core_ack_tgl_q;
			end
		end
	end

	default clocking pgef_cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_sof_flag: assert property (pix_rd_w |=> core_rdata_q[pgef_pkg::SOF_BIT] == ($past(pix_idx_q) == 9'h000))
		else $error("first pixel marker wrong");

	a_valid_flag: assert property (pix_rd_w |=> core_rdata_q[pgef_pkg::VALID_BIT] == $past(held_w))
		else $error("valid flag does not match grabber state");

	a_write_restart: assert property (pix_wr_w |=> pix_idx_q == 9'h000 && grab_q == PGEF_ARMED)
		else $error("pixel port write did not restart grabber");

	a_read_advance: assert property (adv_w && pix_idx_q != pgef_pkg::PIX_LAST |=> pix_idx_q == $past(pix_idx_q) + 9'h001)
		else $error("pixel index did not advance");

	a_index_wrap: assert property (adv_w && pix_idx_q == pgef_pkg::PIX_LAST |=> pix_idx_q == 9'h000)
		else $error("pixel index did not wrap");

	a_one_capture: assert property (cap_w |=> held_w ##1 (held_w || $past(acc_w)))
		else $error("grabber captured more than one pixel");

	a_hold_sample: assert property (held_w && !acc_w |=> $stable(sample_q) && held_w)
		else $error("held pixel changed before read");

	a_frame_reload: assert property (frame_wrap_w |=> frame_cnt_q == {$past(o_frame_interval), 8'h00})
		else $error("frame counter reload wrong");

	a_exp_limit: assert property (frame_wrap_w && $stable(o_frame_interval) |=> o_exposure <= exp_limit_w)
		else $error("exposure above frame limit");

	a_low_latch: assert property (exph_rd_w |=> exp_low_q == $past(o_exposure[7:0]))
		else $error("low byte not latched on high read");

	a_sleep_hold: assert property (i_stay_awake_bit |=> o_awake)
		else $error("sensor slept while forced awake");
endmodule

// ==== pgef_pkg.sv ====
// Package for the pixel grab, exposure and frame timing block.
// Assumes a 20 MHz core clock and a register port driven from the serial link clock.
package pgef_pkg;

	// Core clock rate and sleep timeout
	localparam int CLK_KHZ   = 20000;
	localparam int SLEEP_MS  = 1000;
	localparam int SLEEP_CYC = SLEEP_MS * CLK_KHZ;

	// Register offsets
	localparam logic [6:0] A_CONFIG     = 7'h40;
	localparam logic [6:0] A_PIXEL_PORT = 7'h48;
	localparam logic [6:0] A_EXP_HIGH   = 7'h49;
	localparam logic [6:0] A_EXP_LOW    = 7'h4a;
	localparam logic [6:0] A_FRAME_INT  = 7'h4b;

	// Field positions of the pixel grab port
	localparam int SOF_BIT   = 7;
	localparam int VALID_BIT = 6;

	// Reset values
	localparam logic [7:0]  FRAME_INT_RST = 8'hc2;
	localparam logic [15:0] EXP_RST       = 16'h0100;
	localparam logic [7:0]  PIXEL_RST     = 8'h00;

	// Image geometry and frame timing
	localparam logic [8:0]  PIX_LAST    = 9'h143;
	localparam logic [16:0] FRAME_SPAN  = 17'h10000;
	localparam logic [16:0] EXP_OVH     = 17'h00d94;
	localparam logic [15:0] FRAME_WRAP  = 16'hffff;

	// Auto exposure window, step divider as a shift
	localparam logic [5:0] AE_HIGH  = 6'h3a;
	localparam logic [5:0] AE_LOW   = 6'h34;
	localparam int         AE_SHIFT = 4;

endpackage

// ==== pgef_sync.sv ====
// Two flip-flop level synchroniser.
// Assumes the input is a level that is stable for several destination clocks.
`timescale 1ns/10ps
module pgef_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= 1'b0;
			o_q    <= 1'b0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule

// ==== pgef_auto_exposure.sv ====
// Automatic exposure loop: steps the exposure count once per frame.
// Assumes a one-cycle frame end pulse and the brightest pixel of that frame.
`timescale 1ns/10ps
module pgef_auto_exposure (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_frame_end,
	input  wire logic [5:0]  i_max_pix,
	input  wire logic [15:0] i_limit,
	output logic [15:0]      o_exposure
);
	logic [15:0] exp_d;
	logic [15:0] step_w;
	logic [16:0] up_w;
	logic [15:0] down_w;

	function automatic logic [15:0] clamp(input logic [16:0] v, input logic [15:0] lim);
		clamp = (v > {1'b0, lim}) ? lim : v[15:0];
	endfunction

	assign step_w = ((o_exposure >> pgef_pkg::AE_SHIFT) == 16'h0000) ? 16'h0001 : (o_exposure >> pgef_pkg::AE_SHIFT);
	assign up_w   = {1'b0, o_exposure} + {1'b0, step_w};
	assign down_w = (o_exposure > step_w) ? (o_exposure - step_w) : 16'h0001;

	always_comb begin
		exp_d = o_exposure;
		if (i_frame_end) begin
			if (i_max_pix < pgef_pkg::AE_LOW) begin
				exp_d = clamp(up_w, i_limit);
			end else if (i_max_pix > pgef_pkg::AE_HIGH) begin
				exp_d = clamp({1'b0, down_w}, i_limit);
			end else begin
				exp_d = clamp({1'b0, o_exposure}, i_limit);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_exposure <= pgef_pkg::EXP_RST;
		end else begin
			o_exposure <= exp_d;
		end
	end

	a_step_size: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_frame_end && i_max_pix < pgef_pkg::AE_LOW && up_w <= {1'b0, i_limit})
		|=> (o_exposure == $past(o_exposure) + $past(step_w)))
		else $error("exposure did not rise by one sixteenth");
endmodule

// ==== pgef_host_model.sv ====
// Host model: register master on the link side of the pixel grab core.
// Assumes a free-running link clock and one access at a time.
`timescale 1ns/10ps
module pgef_host_model (
	input  wire logic       i_lnk_clk,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_ack,
	output logic [6:0]      o_addr,
	output logic            o_rd,
	output logic            o_wr,
	output logic [7:0]      o_wdata
);
	initial begin
		o_addr = 7'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end

	// One access: request pulse, qualifiers held until the answer
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge i_lnk_clk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_rd = ~w;
		o_wr = w;
		@(posedge i_lnk_clk);
		#1;
		o_rd = 1'b0;
		o_wr = 1'b0;
		n = 0;
		do begin
			@(posedge i_lnk_clk);
			n++;
		end while (i_ack !== 1'b1 && n < 20);
		q = (i_ack === 1'b1) ? i_rdata : 8'hxx;
		#1;
		o_addr = ~a;
		o_wdata = ~d;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	// Exposure pair: high byte, then low byte straight after
	task automatic rd_exp(output logic [15:0] w);
		logic [7:0] h;
		logic [7:0] l;
		rd(pgef_pkg::A_EXP_HIGH, h);
		rd(pgef_pkg::A_EXP_LOW, l);
		w = {h, l};
	endtask
endmodule

// ==== tb_pixel_grab_exposure_frame_timing.sv ====
// Testbench of the pixel grab, exposure and frame timing core.
// Assumes the host model on the link port and a pixel stream after each frame start.
`timescale 1ns/10ps
module tb_pixel_grab_exposure_frame_timing;
	logic        clk = 1'b0;
	logic        lclk = 1'b0;
	logic        rst = 1'b1;
	logic [6:0]  addr;
	logic        rd;
	logic        wr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        ack;
	logic        pv = 1'b0;
	logic [5:0]  pval = 6'h00;
	logic        awake_req = 1'b1;
	logic        busy;
	logic        shut;
	int          shut_cyc = 0;
	logic        motion = 1'b0;
	logic        hi = 1'b1;
	logic        fs;
	logic        awake;
	logic [15:0] expo;
	logic [7:0]  fint;
	logic [7:0]  q;
	logic [15:0] w;
	int          n;
	int          fails = 0;
	int          n_tests = 0;
	int          cyc = 0;

	always #25 clk = ~clk;
	initial begin
		#7;
		forever #16 lclk = ~lclk;
	end

	pgef_core #(.SLEEP_CYCLES(50)) dut_u (
		.i_clk(clk), .i_rst(rst), .i_lnk_clk(lclk), .i_lnk_addr(addr), .i_lnk_rd(rd),
		.i_lnk_wr(wr), .i_lnk_wdata(wdata), .o_lnk_rdata(rdata), .o_lnk_ack(ack), .o_lnk_busy(busy),
		.i_pix_valid(pv), .i_pix_value(pval), .i_stay_awake_bit(awake_req), .i_motion(motion),
		.o_frame_start(fs), .o_shutter_open(shut), .o_awake(awake), .o_exposure(expo),
		.o_frame_interval(fint)
	);

	pgef_host_model host_u (
		.i_lnk_clk(lclk), .i_rdata(rdata), .i_ack(ack), .o_addr(addr), .o_rd(rd), .o_wr(wr),
		.o_wdata(wdata)
	);

	function automatic logic [5:0] pix(input int k, input logic h);
		return {h, 5'(k % 32)};
	endfunction

	// Imaging array: 324 pixels, column by column, after each frame start
	always @(posedge clk) begin
		if (fs === 1'b1) begin
			for (int k = 0; k < 324; k++) begin
				#1;
				pv = 1'b1;
				pval = pix(k, hi);
				@(posedge clk);
			end
			#1;
			pv = 1'b0;
		end
	end

	// Shutter cycles of the frame just ended, cleared at each frame start
	always @(posedge clk) begin
		if (fs === 1'b1)
			shut_cyc <= 0;
		else if (shut === 1'b1)
			shut_cyc <= shut_cyc + 1;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			complete_run();
		end
	end

	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic wait_frame(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#2;
			c++;
		end while (fs !== 1'b1 && c < 20000);
		if (fs !== 1'b1)
			fails++;
	endtask

	// Wait for the armed capture to complete, then read the pixel port
	task automatic grab(output logic [7:0] v);
		wait_frame(n);
		repeat (340) @(posedge clk);
		host_u.rd(pgef_pkg::A_PIXEL_PORT, v);
	endtask

	task automatic t_reset_values;
		chk_word("exposure", 16'h0100, expo);
		chk_byte("interval out", 8'hc2, fint);
		chk_bit("awake", 1'b1, awake);
		host_u.rd(pgef_pkg::A_FRAME_INT, q);
		chk_byte("interval reg", 8'hc2, q);
		host_u.rd_exp(w);
		chk_word("exposure pair", 16'h0100, w);
		host_u.rd(7'h50, q);
		chk_byte("unmapped", 8'h00, q);
		chk_bit("link busy", 1'b0, busy);
	endtask

	task automatic t_exposure_period;
		wait_frame(n);
		chk_word("exposure up", 16'h0110, expo);
		wait_frame(n);
		chk_word("frame period", 16'd15872, 16'(n));
		chk_word("shutter cycles", 16'h0110, 16'(shut_cyc));
		#100;
		chk_word("exposure down", 16'h00ff, expo);
		host_u.rd_exp(w);
		chk_word("exposure pair", 16'h00ff, w);
		host_u.wr(pgef_pkg::A_FRAME_INT, 8'hfe);
		host_u.rd(pgef_pkg::A_FRAME_INT, q);
		chk_byte("interval reg", 8'hfe, q);
		wait_frame(n);
		chk_word("exposure clamp", 16'h0001, expo);
		wait_frame(n);
		chk_word("frame period", 16'd512, 16'(n));
	endtask

	task automatic t_pixel_grab;
		host_u.wr(pgef_pkg::A_PIXEL_PORT, 8'h5a);
		grab(q);
		chk_byte("first pixel", {2'b11, pix(0, 1'b1)}, q);
		host_u.rd(pgef_pkg::A_PIXEL_PORT, q);
		chk_bit("valid on reread", 1'b0, q[6]);
		for (int k = 1; k < 20; k++) begin
			grab(q);
			chk_byte("pixel", {2'b01, pix(k, 1'b1)}, q);
		end
	endtask

	task automatic t_hold_restart;
		wait_frame(n);
		repeat (340) @(posedge clk);
		#1 hi = 1'b0;
		wait_frame(n);
		wait_frame(n);
		host_u.rd(pgef_pkg::A_PIXEL_PORT, q);
		chk_byte("held pixel", {2'b01, pix(20, 1'b1)}, q);
		host_u.wr(pgef_pkg::A_PIXEL_PORT, 8'h00);
		grab(q);
		chk_byte("restart pixel", {2'b11, pix(0, 1'b0)}, q);
	endtask

	task automatic t_sleep;
		@(posedge clk);
		#1 awake_req = 1'b0;
		repeat (80) @(posedge clk);
		chk_bit("asleep", 1'b0, awake);
		host_u.wr(pgef_pkg::A_PIXEL_PORT, 8'h00);
		grab(q);
		chk_bit("no capture asleep", 1'b0, q[6]);
		@(posedge clk);
		#1 motion = 1'b1;
		awake_req = 1'b1;
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		t_reset_values();
		t_exposure_period();
		t_pixel_grab();
		t_hold_restart();
		t_sleep();
		complete_run();
	end
endmodule
